// ---- include/tst_params.svh ----
`ifndef TST_PARAMS_SVH
`define TST_PARAMS_SVH
// -------------------------------------------------------------------------
// How it works
// - Own address with read acked reports A8; ack_enable low makes next byte last.
// - Lost arbitration then addressed for read reports B0; loading as for A8.
// - Data byte acked by master reports B8; next byte last or ordinary.
// - Data byte NACKed reports C0; after clear, return to not-addressed slave.
// - Last byte acked anyway reports C8; then not-addressed slave like C0.
// - General call address is recognised only while general call enable is set.
// - Status reads F8 whenever the done flag is clear.
// - START or STOP inside an address, data or acknowledge bit is a bus error.
// - A bus error sets the done flag with status 00.
// - Recovery enters not-addressed slave, clears only stop bit, lines released.
// - A repeated START keeps the bus with the master and restarts addressing.
// - Status code sits in bits 7..3; prescaler bits 1..0; bit 2 reads zero.
// - While the done flag is set the clock line is held low, except after a bus error, which releases it.
// - Own address is seven bits; general call enable selects address zero.
// -------------------------------------------------------------------------

// Status codes with the prescaler bits masked to zero
`define TST_ST_SLA_READ 8'ha8
`define TST_ST_ARB_READ 8'hb0
`define TST_ST_DATA_ACK 8'hb8
`define TST_ST_DATA_NACK 8'hc0
`define TST_ST_LAST_ACK 8'hc8
`define TST_ST_IDLE 8'hf8
`define TST_ST_BUS_ERR 8'h00
`define TST_STATUS_MASK 8'hf8

// Frame and buffer figures
`define TST_ADDR_BITS 4'h8
`define TST_LAST_DATA_BIT 4'h7
`define TST_BUF_DEPTH 2'h2
`define TST_GC_ADDR 7'h00

`endif

// ---- include/tst_pkg.sv ----
package tst_pkg;
  // Slave engine states
  typedef enum logic [3:0] {
    s_idle, s_addr, s_addr_ack, s_ignore, s_wait_load,
    s_tx, s_tx_ack, s_wait_end, s_bus_err
  } tst_state_t;
  typedef logic [7:0] tst_byte_t;
endpackage : tst_pkg

// ---- core/tst_core.sv ----
`timescale 1ns/1ns
`include "tst_params.svh"

module tst_core
  import tst_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Two-wire bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Configuration levels
  input wire logic [6:0] own_slave_address,
  input wire logic general_call_enable,
  input wire logic ack_enable,
  input wire logic start_request,
  input wire logic [1:0] prescaler_field,
  input wire logic arb_lost_in_addr,
  // Control writes
  input wire logic sw_write,
  input wire logic sw_flag_clear,
  input wire logic sw_stop,
  // Transmit data stream
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // Status
  output logic job_done_flag,
  output logic [7:0] serial_status_reg,
  output logic stop_request_bit,
  output logic start_pending
);

  // -----------------------------------------------------------------------
  // Bus line synchronisers and condition detection
  // -----------------------------------------------------------------------
  logic scl_meta, scl_sync, scl_prev;
  logic sda_meta, sda_sync, sda_prev;
  logic scl_rise, scl_fall, start_cond, stop_cond;

  // Two stages before use, a third stage only for edge detection
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_meta <= scl_in;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= sda_in;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
    end
  end

  assign scl_rise = scl_sync & ~scl_prev;
  assign scl_fall = ~scl_sync & scl_prev;
  assign start_cond = scl_sync & scl_prev & sda_prev & ~sda_sync;
  assign stop_cond = scl_sync & scl_prev & ~sda_prev & sda_sync;

  // -----------------------------------------------------------------------
  // Two-entry transmit buffer
  // -----------------------------------------------------------------------
  tst_byte_t mem [2];
  logic wptr, rptr, next_wptr, next_rptr;
  logic [1:0] bcnt, next_bcnt;
  logic next_tx_ready, push, pop;
  tst_byte_t buf_head;

  // Ready is registered so software sees a clean stall when both are full
  always_comb begin
    push = tx_valid & tx_ready;
    next_wptr = wptr ^ push;
    next_rptr = rptr ^ pop;
    next_bcnt = bcnt + {1'b0, push} - {1'b0, pop};
    next_tx_ready = (next_bcnt != `TST_BUF_DEPTH);
    buf_head = mem[rptr];
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wptr <= 1'b0;
      rptr <= 1'b0;
      bcnt <= 2'h0;
      tx_ready <= 1'b0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      bcnt <= next_bcnt;
      tx_ready <= next_tx_ready;
    end
  end

  // Storage needs no reset; the count guards every read
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wptr] <= tx_data;
    end
  end

  // -----------------------------------------------------------------------
  // Slave transmitter engine
  // -----------------------------------------------------------------------
  tst_state_t state, next_state;
  tst_byte_t shift, next_shift, code, next_code, next_status;
  logic [3:0] cnt, next_cnt;
  logic is_read, next_is_read, last, next_last;
  logic ack_seen, next_ack_seen, next_flag, next_sda_oe, next_scl_oe;
  logic next_stop_bit, next_start_pending;
  logic set_flag, bus_err, in_frame, flag_clr;

  // Address recognition, gated by ack_enable
  function automatic logic addr_hit(input logic [6:0] a, input logic rw,
                                    input logic [6:0] own, input logic gce,
                                    input logic en);
    addr_hit = en & ((a == own) |
               (gce & ~rw & (a == `TST_GC_ADDR)));
  endfunction : addr_hit

  always_comb begin
    next_state = state;
    next_shift = shift;
    next_cnt = cnt;
    next_is_read = is_read;
    next_last = last;
    next_ack_seen = ack_seen;
    next_code = code;
    next_sda_oe = sda_oe;
    next_scl_oe = scl_oe;
    next_stop_bit = stop_request_bit;
    next_start_pending = start_pending & start_request;
    set_flag = 1'b0;
    pop = 1'b0;
    flag_clr = sw_write & sw_flag_clear;
    in_frame = ((state == s_addr) && (cnt != 4'h0)) ||
               (state == s_addr_ack) || (state == s_tx) ||
               (state == s_tx_ack);
    bus_err = (start_cond | stop_cond) & in_frame;
    case (state)
      s_idle, s_ignore: begin
        // A repeated START re-enters addressing without losing the bus
        if (start_cond) begin
          next_state = s_addr;
          next_cnt = 4'h0;
        end else if (stop_cond) begin
          next_state = s_idle;
        end
      end
      s_addr: begin
        if (start_cond) begin
          next_cnt = 4'h0;
        end else if (stop_cond) begin
          next_state = s_idle;
        end else if (scl_rise) begin
          next_shift = {shift[6:0], sda_sync};
          next_cnt = cnt + 4'h1;
        end else if (scl_fall && cnt == `TST_ADDR_BITS) begin
          next_is_read = shift[0];
          if (addr_hit(shift[7:1], shift[0], own_slave_address,
                       general_call_enable, ack_enable)) begin
            next_sda_oe = 1'b1;
            next_state = s_addr_ack;
          end else begin
            next_state = s_ignore;
          end
        end
      end
      s_addr_ack: begin
        // Write direction belongs to the receiver path; stand aside
        if (scl_fall) begin
          next_sda_oe = 1'b0;
          if (is_read) begin
            set_flag = 1'b1;
            next_scl_oe = 1'b1;
            next_state = s_wait_load;
            next_code = arb_lost_in_addr ? `TST_ST_ARB_READ
                                         : `TST_ST_SLA_READ;
          end else begin
            next_state = s_ignore;
          end
        end
      end
      s_wait_load: begin
        // Clock stays low until the flag is cleared and a byte is there
        if (!job_done_flag && bcnt != 2'h0) begin
          pop = 1'b1;
          next_shift = buf_head;
          next_last = ~ack_enable;
          next_sda_oe = ~buf_head[7];
          next_cnt = 4'h0;
          next_scl_oe = 1'b0;
          next_state = s_tx;
        end
      end
      s_tx: begin
        if (scl_fall) begin
          if (cnt == `TST_LAST_DATA_BIT) begin
            next_sda_oe = 1'b0;
            next_state = s_tx_ack;
          end else begin
            next_shift = {shift[6:0], 1'b0};
            next_sda_oe = ~shift[6];
            next_cnt = cnt + 4'h1;
          end
        end
      end
      s_tx_ack: begin
        if (scl_rise) begin
          next_ack_seen = ~sda_sync;
        end else if (scl_fall) begin
          set_flag = 1'b1;
          next_scl_oe = 1'b1;
          if (!ack_seen) begin
            next_code = `TST_ST_DATA_NACK;
            next_state = s_wait_end;
          end else if (last) begin
            next_code = `TST_ST_LAST_ACK;
            next_state = s_wait_end;
          end else begin
            next_code = `TST_ST_DATA_ACK;
            next_state = s_wait_load;
          end
        end
      end
      s_wait_end: begin
        // Master that keeps clocking after C8 only sees released lines
        if (!job_done_flag) begin
          next_scl_oe = 1'b0;
          next_start_pending = start_request;
          next_state = s_idle;
        end
      end
      s_bus_err: begin
        // Only the stop bit is cleared; no STOP is driven
        if (!job_done_flag && stop_request_bit) begin
          next_stop_bit = 1'b0;
          next_state = s_idle;
        end
      end
      default: begin
        next_state = s_idle;
      end
    endcase
    if (bus_err) begin
      set_flag = 1'b1;
      next_code = `TST_ST_BUS_ERR;
      next_sda_oe = 1'b0;
      next_scl_oe = 1'b0;
      next_state = s_bus_err;
    end
    // Software set of the stop bit wins over the hardware clear
    if (sw_write && sw_stop) begin
      next_stop_bit = 1'b1;
    end
    // An event in the clearing cycle is kept
    next_flag = set_flag | (job_done_flag & ~flag_clr);
    next_status = (next_flag ? next_code : `TST_ST_IDLE) |
                  {6'h00, prescaler_field};
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= s_idle;
      shift <= 8'h00;
      cnt <= 4'h0;
      is_read <= 1'b0;
      last <= 1'b0;
      ack_seen <= 1'b0;
      code <= `TST_ST_IDLE;
      job_done_flag <= 1'b0;
      serial_status_reg <= `TST_ST_IDLE;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
      stop_request_bit <= 1'b0;
      start_pending <= 1'b0;
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end else begin
      state <= next_state;
      shift <= next_shift;
      cnt <= next_cnt;
      is_read <= next_is_read;
      last <= next_last;
      ack_seen <= next_ack_seen;
      code <= next_code;
      job_done_flag <= next_flag;
      serial_status_reg <= next_status;
      sda_oe <= next_sda_oe;
      scl_oe <= next_scl_oe;
      stop_request_bit <= next_stop_bit;
      start_pending <= next_start_pending;
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end
  end

  // -----------------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_idle_code;
    !job_done_flag |->
      (serial_status_reg & `TST_STATUS_MASK) == `TST_ST_IDLE;
  endproperty
  a_idle_code: assert property (p_idle_code)
    else $error("status not F8 while flag clear");

  property p_sla_read;
    state == s_addr_ack && scl_fall && is_read && !arb_lost_in_addr |=>
      job_done_flag && scl_oe && state == s_wait_load &&
      (serial_status_reg & `TST_STATUS_MASK) == `TST_ST_SLA_READ;
  endproperty
  a_sla_read: assert property (p_sla_read)
    else $error("read address not reported as A8");

  property p_arb_read;
    state == s_addr_ack && scl_fall && is_read && arb_lost_in_addr |=>
      (serial_status_reg & `TST_STATUS_MASK) == `TST_ST_ARB_READ;
  endproperty
  a_arb_read: assert property (p_arb_read)
    else $error("arbitration read not reported as B0");

  property p_data_ack;
    state == s_tx_ack && scl_fall && ack_seen && !last |=>
      job_done_flag ##0 state == s_wait_load ##0
      (serial_status_reg & `TST_STATUS_MASK) == `TST_ST_DATA_ACK;
  endproperty
  a_data_ack: assert property (p_data_ack)
    else $error("acked byte not reported as B8");

  property p_data_nack;
    state == s_tx_ack && scl_fall && !ack_seen |=>
      (serial_status_reg & `TST_STATUS_MASK) == `TST_ST_DATA_NACK;
  endproperty
  a_data_nack: assert property (p_data_nack)
    else $error("nacked byte not reported as C0");

  property p_last_ack;
    state == s_tx_ack && scl_fall && ack_seen && last |=>
      state == s_wait_end && !sda_oe &&
      (serial_status_reg & `TST_STATUS_MASK) == `TST_ST_LAST_ACK;
  endproperty
  a_last_ack: assert property (p_last_ack)
    else $error("acked last byte not reported as C8");

  property p_bus_err;
    bus_err |=> job_done_flag && !sda_oe && !scl_oe &&
      (serial_status_reg & `TST_STATUS_MASK) == `TST_ST_BUS_ERR;
  endproperty
  a_bus_err: assert property (p_bus_err)
    else $error("bus error not flagged or lines held");

  property p_recover;
    state == s_bus_err && !job_done_flag && stop_request_bit &&
      !(sw_write && sw_stop) |=> state == s_idle && !stop_request_bit;
  endproperty
  a_recover: assert property (p_recover)
    else $error("bus error recovery failed");

  property p_stretch;
    job_done_flag && (state == s_wait_load || state == s_wait_end) |->
      scl_oe;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("clock not held while flag set");

  property p_gen_call;
    state == s_addr && scl_fall && cnt == `TST_ADDR_BITS &&
      shift == 8'h00 && ack_enable && general_call_enable |=>
      sda_oe && state == s_addr_ack;
  endproperty
  a_gen_call: assert property (p_gen_call)
    else $error("general call not acknowledged");

  c_byte_acked: cover property (state == s_tx_ack && scl_fall && ack_seen);
  c_last_acked: cover property (state == s_wait_end && job_done_flag &&
                                code == `TST_ST_LAST_ACK);
  c_bus_error: cover property (bus_err);
  c_full_stall: cover property (tx_valid && !tx_ready);

endmodule : tst_core

// ---- dv/tst_master.sv ----
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Two-wire bus master receiver model
// ---------------------------------------------------------------
module tst_master (
  // Pacing clock
  input wire logic mclk,
  // Resolved bus levels
  input wire logic scl,
  input wire logic sda,
  // Open-drain pull-downs, high pulls the line low
  output logic scl_low,
  output logic sda_low,
  // Set if a stretched clock never came back
  output logic hang
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    hang = 1'b0;
  end
  // Half bit of ten cycles leaves room for the two-flop sync
  task automatic half;
    repeat (10) @(negedge mclk);
  endtask : half
  // Release SCL and honour stretching, bounded so a hang is seen
  task automatic rise;
    int n;
    scl_low = 1'b0;
    n = 0;
    while (scl !== 1'b1 && n < 4000) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 4000) hang = 1'b1;
  endtask : rise
  // START; from a low SCL it is a repeated START keeping the bus
  task automatic start_c;
    sda_low = 1'b0;
    half;
    rise;
    half;
    sda_low = 1'b1;
    half;
    scl_low = 1'b1;
    half;
  endtask : start_c
  task automatic stop_c;
    sda_low = 1'b1;
    half;
    rise;
    half;
    sda_low = 1'b0;
    half;
  endtask : stop_c
  // One bit: data set while SCL low, sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    sda_low = ~b;
    half;
    rise;
    half;
    r = sda;
    scl_low = 1'b1;
    half;
  endtask : bit_io
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, ack);
  endtask : wr_byte
  task automatic rd_byte(input logic ack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(ack, r);
  endtask : rd_byte
endmodule : tst_master

// ---- dv/twowire_slave_tx_status_bench.sv ----
`timescale 1ns/1ns
`include "tst_params.svh"
// ---------------------------------------------------------------
// Slave transmitter bench
// ---------------------------------------------------------------
module twowire_slave_tx_status_bench
  import tst_pkg::*;
;
  typedef struct {logic [7:0] code; logic ae; logic stop;} tst_note_t;
  logic mclk, rst_n, scl, sda, scl_oe, sda_oe, m_scl_low, m_sda_low;
  logic gce, ae, sr, arb, sw_write, sw_flag_clear, sw_stop, hang;
  logic scl_o, sda_o;
  logic tx_valid, tx_ready, job_done_flag, stop_request_bit, start_pending;
  logic [6:0] own;
  logic [1:0] presc;
  logic [7:0] serial_status_reg;
  tst_byte_t tx_data;
  tst_note_t notes[$];
  int failures = 0;
  int num_checks = 0;
  // Open-drain lines with pull-ups
  assign scl = ~(scl_oe | m_scl_low);
  assign sda = ~(sda_oe | m_sda_low);
  initial mclk = 1'b0;
  always #50 mclk = ~mclk;
  tst_core tst_core_i (.mclk(mclk), .rst_n(rst_n), .scl_in(scl),
    .scl_out(scl_o), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_o),
    .sda_oe(sda_oe), .own_slave_address(own), .general_call_enable(gce),
    .ack_enable(ae), .start_request(sr), .prescaler_field(presc),
    .arb_lost_in_addr(arb), .sw_write(sw_write),
    .sw_flag_clear(sw_flag_clear), .sw_stop(sw_stop), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready),
    .job_done_flag(job_done_flag), .serial_status_reg(serial_status_reg),
    .stop_request_bit(stop_request_bit), .start_pending(start_pending));
  tst_master tst_master_i (.mclk(mclk), .scl(scl), .sda(sda),
    .scl_low(m_scl_low), .sda_low(m_sda_low), .hang(hang));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic conclude;
    if (failures == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  // Offer one byte; bounded so a stuck buffer ends the run
  task automatic push(input tst_byte_t b);
    int n;
    n = 0;
    @(negedge mclk);
    while (tx_ready !== 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 200) begin
      failures++;
      conclude;
    end
    tx_valid = 1'b1;
    tx_data = b;
    @(negedge mclk);
    tx_valid = 1'b0;
  endtask : push
  // Software stand-in: compare each status, then answer it
  initial begin
    logic prev;
    tst_note_t nt;
    prev = 1'b0;
    forever begin
      @(negedge mclk);
      if (job_done_flag === 1'b1 && prev !== 1'b1) begin
        nt = '{8'hxx, 1'b1, 1'b0};
        if (notes.size() > 0) nt = notes.pop_front();
        check(serial_status_reg, {nt.code[7:3], 1'b0, presc});
        if (nt.code === `TST_ST_BUS_ERR) check({6'h0, scl_oe, sda_oe}, 8'h00);
        else check({7'h0, scl_oe}, 8'h01);
        repeat (5) @(negedge mclk);
        ae = nt.ae;
        sw_write = 1'b1;
        sw_flag_clear = 1'b1;
        sw_stop = nt.stop;
        @(negedge mclk);
        sw_write = 1'b0;
        sw_flag_clear = 1'b0;
        sw_stop = 1'b0;
        check(serial_status_reg, {5'h1f, 1'b0, presc});
      end
      prev = job_done_flag;
    end
  end
  // Main sequence
  initial begin
    logic ack;
    logic [6:0] other;
    tst_byte_t b0, b1, b2, got;
    {rst_n, sw_write, sw_flag_clear, sw_stop, tx_valid} = 5'h00;
    {gce, ae, sr, arb} = 4'h4;
    tx_data = 8'h00;
    void'($urandom(32'hd1e5));
    presc = 2'($urandom_range(3, 0));
    own = 7'($urandom_range(127, 1));
    other = own ^ 7'h01;
    sr = 1'($urandom_range(1, 0));
    b0 = 8'($urandom);
    b1 = 8'($urandom);
    b2 = 8'($urandom);
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    repeat (2) @(negedge mclk);
    check(serial_status_reg, {5'h1f, 1'b0, presc});
    check({7'h0, job_done_flag}, 8'h00);
    // Fill the two-entry buffer until it refuses
    push(b0);
    push(b1);
    @(negedge mclk);
    check({7'h0, tx_ready}, 8'h00);
    // Address-only write, then read through a repeated START
    notes.push_back('{`TST_ST_SLA_READ, 1'b1, 1'b0});
    tst_master_i.start_c;
    tst_master_i.wr_byte({own, 1'b0}, ack);
    check({7'h0, ack}, 8'h00);
    tst_master_i.start_c;
    tst_master_i.wr_byte({own, 1'b1}, ack);
    check({7'h0, ack}, 8'h00);
    notes.push_back('{`TST_ST_DATA_ACK, 1'b1, 1'b0});
    tst_master_i.rd_byte(1'b0, got);
    check(got, b0);
    notes.push_back('{`TST_ST_DATA_NACK, 1'b1, 1'b0});
    tst_master_i.rd_byte(1'b1, got);
    check(got, b1);
    tst_master_i.stop_c;
    check({7'h0, start_pending}, {7'h0, sr});
    // START in mid-address is a bus error; recover with stop set
    notes.push_back('{`TST_ST_BUS_ERR, 1'b1, 1'b1});
    tst_master_i.start_c;
    for (int i = 6; i >= 4; i--) tst_master_i.bit_io(own[i], ack);
    tst_master_i.start_c;
    tst_master_i.stop_c;
    check({7'h0, stop_request_bit}, 8'h00);
    // Other address, general call off and on, own address ignored
    for (int i = 0; i < 4; i++) begin
      gce = (i == 2);
      ae = (i != 3);
      tst_master_i.start_c;
      tst_master_i.wr_byte(i == 0 ? {other, 1'b1} :
        (i == 3 ? {own, 1'b1} : 8'h00), ack);
      check({7'h0, ack}, i == 2 ? 8'h00 : 8'h01);
      tst_master_i.stop_c;
    end
    ae = 1'b1;
    // Lost arbitration, then a last byte the master still acks
    arb = 1'b1;
    push(b2);
    notes.push_back('{`TST_ST_ARB_READ, 1'b0, 1'b0});
    tst_master_i.start_c;
    tst_master_i.wr_byte({own, 1'b1}, ack);
    check({7'h0, ack}, 8'h00);
    arb = 1'b0;
    notes.push_back('{`TST_ST_LAST_ACK, 1'b1, 1'b0});
    tst_master_i.rd_byte(1'b0, got);
    check(got, b2);
    tst_master_i.stop_c;
    repeat (20) @(negedge mclk);
    check(8'(notes.size()), 8'h00);
    check({7'h0, hang}, 8'h00);
    // Open drain: the drive values must never be high
    check({6'h0, scl_o, sda_o}, 8'h00);
    conclude;
  end
endmodule : twowire_slave_tx_status_bench
